// File: logic/aurb_pkg.sv
// Constants for the upper register bank of the accelerometer
// ==========================================================
package aurb_pkg;
  // ==========================================================
  // Map
  localparam int REG_COUNT = 21;
  localparam int IDX_W = 5;
  localparam logic [7:0] ADDR_FIRST = 8'h1d;
  localparam logic [7:0] ADDR_LAST = 8'h31;
  localparam logic [7:0] ADDR_WRAP = 8'h0d;
  localparam logic [7:0] ADDR_CLEARED = 8'h00;
  localparam logic [7:0] ADDR_STEP = 8'h01;
  localparam logic [7:0] ADDR_TRANSIENT_CONFIG = 8'h1d;
  localparam logic [7:0] ADDR_TRANSIENT_EVENT_SOURCE = 8'h1e;
  localparam logic [7:0] ADDR_TRANSIENT_THRESHOLD = 8'h1f;
  localparam logic [7:0] ADDR_TRANSIENT_DEBOUNCE = 8'h20;
  localparam logic [7:0] ADDR_TAP_ENABLE_CONFIG = 8'h21;
  localparam logic [7:0] ADDR_TAP_EVENT_SOURCE = 8'h22;
  localparam logic [7:0] ADDR_TAP_THRESHOLD_X = 8'h23;
  localparam logic [7:0] ADDR_TAP_THRESHOLD_Y = 8'h24;
  localparam logic [7:0] ADDR_TAP_THRESHOLD_Z = 8'h25;
  localparam logic [7:0] ADDR_TAP_TIME_LIMIT = 8'h26;
  localparam logic [7:0] ADDR_TAP_SECOND_LATENCY = 8'h27;
  localparam logic [7:0] ADDR_TAP_SECOND_WINDOW = 8'h28;
  localparam logic [7:0] ADDR_AUTO_SLEEP_COUNT = 8'h29;
  localparam logic [7:0] ADDR_RATE_MODE_CONTROL = 8'h2a;
  localparam logic [7:0] ADDR_SLEEP_OVERSAMPLE_CONTROL = 8'h2b;
  localparam logic [7:0] ADDR_WAKE_PIN_POLARITY_CONTROL = 8'h2c;
  localparam logic [7:0] ADDR_INTERRUPT_ENABLE = 8'h2d;
  localparam logic [7:0] ADDR_INTERRUPT_PIN_MAP = 8'h2e;
  localparam logic [7:0] ADDR_X_AXIS_OFFSET = 8'h2f;
  localparam logic [7:0] ADDR_Y_AXIS_OFFSET = 8'h30;
  localparam logic [7:0] ADDR_Z_AXIS_OFFSET = 8'h31;
  // ==========================================================
  // Fields and values
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] READ_OUTSIDE = 8'h00;
  localparam int ACTIVE_BIT = 0;
  localparam int SOFT_RESET_BIT = 6;
  localparam logic [7:0] ACTIVE_MASK = 8'h01;
  localparam logic [7:0] SOFT_RESET_MASK = 8'h40;
endpackage

// File: logic/aurb_pointer.sv
// Auto-increment register pointer for the upper register bank
`timescale 1ns/1ps
module aurb_pointer
  import aurb_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic stop_i,
  input wire logic addr_load_i,
  input wire logic [7:0] addr_i,
  input wire logic rd_advance_i,
  output logic [7:0] ptr_o
);
  import aurb_pkg::*;

  logic [7:0] ptr_reg;
  logic [7:0] ptr_next;

  // ==========================================================
  // Next pointer
  always_comb begin
    ptr_next = ptr_reg;
    if (stop_i) begin
      ptr_next = ADDR_CLEARED;
    end else if (addr_load_i) begin
      ptr_next = addr_i;
    end else if (rd_advance_i) begin
      if (ptr_reg == ADDR_LAST) begin
        ptr_next = ADDR_WRAP;
      end else begin
        ptr_next = ptr_reg + ADDR_STEP;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ptr_reg <= ADDR_CLEARED;
    end else begin
      ptr_reg <= ptr_next;
    end
  end

  assign ptr_o = ptr_reg;

  // ==========================================================
  // Checks
  a_ptr_wrap_last: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    rd_advance_i && !stop_i && !addr_load_i && ptr_reg == ADDR_LAST
    |=> ptr_reg == ADDR_WRAP)
    else $error("pointer did not wrap after last register");
  a_ptr_step_one: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    rd_advance_i && !stop_i && !addr_load_i
    && ptr_reg >= ADDR_FIRST && ptr_reg < ADDR_LAST
    |=> ptr_reg == $past(ptr_reg) + ADDR_STEP)
    else $error("pointer did not advance by one");
  a_stop_clears_ptr: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    stop_i |=> ptr_reg == ADDR_CLEARED)
    else $error("stop did not clear pointer");
  a_no_advance_idle: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    !rd_advance_i && !stop_i && !addr_load_i |=> $stable(ptr_reg))
    else $error("pointer moved without a burst read");
endmodule // aurb_pointer

// File: logic/aurb_upper_regs.sv
// Upper register bank: storage, write rules, mode effects, burst reads
`timescale 1ns/1ps
module aurb_upper_regs
  import aurb_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic stop_i,
  input wire logic addr_load_i,
  input wire logic [7:0] addr_i,
  input wire logic wr_strobe_i,
  input wire logic [7:0] wr_data_i,
  input wire logic rd_strobe_i,
  input wire logic transient_event_i,
  input wire logic [7:0] transient_event_data_i,
  input wire logic tap_event_i,
  input wire logic [7:0] tap_event_data_i,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  output logic active_mode_o,
  output logic soft_reset_o,
  output logic transient_debounce_clr_o,
  output logic tap_debounce_clr_o,
  output logic [aurb_pkg::REG_COUNT*8-1:0] reg_image_o
);
  import aurb_pkg::*;

  // ==========================================================
  // Address helpers
  function automatic logic in_bank(input logic [7:0] a);
    in_bank = (a >= ADDR_FIRST) && (a <= ADDR_LAST);
  endfunction

  function automatic logic [IDX_W-1:0] idx_of(input logic [7:0] a);
    logic [7:0] d;
    d = a - ADDR_FIRST;
    idx_of = d[IDX_W-1:0];
  endfunction

  function automatic logic anytime_reg(input logic [7:0] a);
    anytime_reg = (a == ADDR_TRANSIENT_THRESHOLD)
      || (a == ADDR_TRANSIENT_DEBOUNCE)
      || (a == ADDR_TAP_THRESHOLD_X)
      || (a == ADDR_TAP_THRESHOLD_Y)
      || (a == ADDR_TAP_THRESHOLD_Z);
  endfunction

  function automatic logic source_reg(input logic [7:0] a);
    source_reg = (a == ADDR_TRANSIENT_EVENT_SOURCE)
      || (a == ADDR_TAP_EVENT_SOURCE);
  endfunction

  // ==========================================================
  // State
  logic [7:0] regs_reg [REG_COUNT];
  logic [7:0] regs_next [REG_COUNT];
  logic [7:0] rd_data_reg;
  logic [7:0] rd_data_next;
  logic rd_valid_reg;
  logic rd_valid_next;
  logic trans_clr_reg;
  logic trans_clr_next;
  logic tap_clr_reg;
  logic tap_clr_next;
  logic [7:0] ptr;
  logic active_now;
  logic soft_reset_now;
  logic bank_write;
  logic activating;
  logic [7:0] ctrl1_now;
  logic [7:0] ctrl2_now;

  aurb_pointer u_pointer (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .stop_i(stop_i),
    .addr_load_i(addr_load_i),
    .addr_i(addr_i),
    .rd_advance_i(rd_strobe_i),
    .ptr_o(ptr)
  );

  assign ctrl1_now = regs_reg[idx_of(ADDR_RATE_MODE_CONTROL)];
  assign ctrl2_now = regs_reg[idx_of(ADDR_SLEEP_OVERSAMPLE_CONTROL)];
  assign active_now = ctrl1_now[ACTIVE_BIT];
  assign soft_reset_now = ctrl2_now[SOFT_RESET_BIT];
  assign bank_write = wr_strobe_i && in_bank(ptr) && !soft_reset_now;
  // Only a write that raises the active bit counts as activation
  assign activating = bank_write && (ptr == ADDR_RATE_MODE_CONTROL)
    && wr_data_i[ACTIVE_BIT] && !active_now;

  // ==========================================================
  // Register next values
  always_comb begin
    for (int i = 0; i < REG_COUNT; i++) begin
      regs_next[i] = regs_reg[i];
    end
    if (soft_reset_now) begin
      // Soft reset clears the bank, the reset bit included
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_next[i] = REG_RESET;
      end
    end else if (bank_write) begin
      if (source_reg(ptr)) begin
        regs_next[idx_of(ptr)] = regs_reg[idx_of(ptr)];
      end else if (anytime_reg(ptr) || !active_now) begin
        regs_next[idx_of(ptr)] = wr_data_i;
      end else if (ptr == ADDR_RATE_MODE_CONTROL) begin
        regs_next[idx_of(ptr)] = (ctrl1_now & ~ACTIVE_MASK)
          | (wr_data_i & ACTIVE_MASK);
      end else if (ptr == ADDR_SLEEP_OVERSAMPLE_CONTROL) begin
        regs_next[idx_of(ptr)] = (ctrl2_now & ~SOFT_RESET_MASK)
          | (wr_data_i & SOFT_RESET_MASK);
      end else begin
        regs_next[idx_of(ptr)] = regs_reg[idx_of(ptr)];
      end
    end
    // Going active clears both source registers; going to standby touches nothing else
    if (activating) begin
      regs_next[idx_of(ADDR_TRANSIENT_EVENT_SOURCE)] = REG_RESET;
      regs_next[idx_of(ADDR_TAP_EVENT_SOURCE)] = REG_RESET;
    end
    // Events are applied last so a same-cycle activation clear cannot lose them
    if (transient_event_i && !soft_reset_now) begin
      regs_next[idx_of(ADDR_TRANSIENT_EVENT_SOURCE)] =
        regs_next[idx_of(ADDR_TRANSIENT_EVENT_SOURCE)]
        | transient_event_data_i;
    end
    if (tap_event_i && !soft_reset_now) begin
      regs_next[idx_of(ADDR_TAP_EVENT_SOURCE)] =
        regs_next[idx_of(ADDR_TAP_EVENT_SOURCE)] | tap_event_data_i;
    end
  end

  // ==========================================================
  // Read data and debounce-clear strobes
  always_comb begin
    rd_valid_next = rd_strobe_i;
    rd_data_next = rd_data_reg;
    if (rd_strobe_i) begin
      rd_data_next = in_bank(ptr) ? regs_reg[idx_of(ptr)] : READ_OUTSIDE;
    end
    trans_clr_next = bank_write && ((ptr == ADDR_TRANSIENT_THRESHOLD)
      || (ptr == ADDR_TRANSIENT_DEBOUNCE));
    tap_clr_next = bank_write && ((ptr == ADDR_TAP_THRESHOLD_X)
      || (ptr == ADDR_TAP_THRESHOLD_Y)
      || (ptr == ADDR_TAP_THRESHOLD_Z));
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_reg[i] <= REG_RESET;
      end
      rd_data_reg <= REG_RESET;
      rd_valid_reg <= 1'b0;
      trans_clr_reg <= 1'b0;
      tap_clr_reg <= 1'b0;
    end else begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_reg[i] <= regs_next[i];
      end
      rd_data_reg <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
      trans_clr_reg <= trans_clr_next;
      tap_clr_reg <= tap_clr_next;
    end
  end

  // ==========================================================
  // Outputs
  always_comb begin
    for (int i = 0; i < REG_COUNT; i++) begin
      reg_image_o[i*8 +: 8] = regs_reg[i];
    end
  end

  assign rd_data_o = rd_data_reg;
  assign rd_valid_o = rd_valid_reg;
  assign active_mode_o = active_now;
  assign soft_reset_o = soft_reset_now;
  assign transient_debounce_clr_o = trans_clr_reg;
  assign tap_debounce_clr_o = tap_clr_reg;

  // ==========================================================
  // Checks
  a_activate_clears_src: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    activating && !transient_event_i && !tap_event_i
    |=> regs_reg[idx_of(ADDR_TRANSIENT_EVENT_SOURCE)] == REG_RESET
    && regs_reg[idx_of(ADDR_TAP_EVENT_SOURCE)] == REG_RESET)
    else $error("activation left a source register set");
  a_anytime_write_lands: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    bank_write && anytime_reg(ptr)
    |=> regs_reg[idx_of($past(ptr))] == $past(wr_data_i))
    else $error("threshold write was not stored");
  a_debounce_clr_pulse: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    bank_write && ptr == ADDR_TRANSIENT_THRESHOLD
    |=> transient_debounce_clr_o ##1 !transient_debounce_clr_o
      || $past(bank_write))
    else $error("transient debounce clear missing");
  a_locked_in_active: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    bank_write && active_now && ptr == ADDR_TRANSIENT_CONFIG
    |=> $stable(regs_reg[idx_of(ADDR_TRANSIENT_CONFIG)]))
    else $error("locked register changed while active");
  a_active_bit_free: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    bank_write && ptr == ADDR_RATE_MODE_CONTROL
    |=> active_mode_o == $past(wr_data_i[ACTIVE_BIT]))
    else $error("active bit write was not taken");
  a_source_read_only: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    wr_strobe_i && ptr == ADDR_TAP_EVENT_SOURCE && !tap_event_i
    && !activating && !soft_reset_now
    |=> $stable(regs_reg[idx_of(ADDR_TAP_EVENT_SOURCE)]))
    else $error("source register changed on write");
  a_read_returns_reg: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    rd_strobe_i && in_bank(ptr)
    |=> rd_valid_o && rd_data_o == $past(regs_reg[idx_of(ptr)]))
    else $error("read data mismatch");

  // ==========================================================
  // Checks on mode changes, events, debounce strobes, writes and reads
  // Writes below are qualified by bank_write or by !soft_reset_now, so a soft reset in
  // flight never makes them fire against a cleared bank
  a_standby_keeps: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    bank_write && active_now && ptr == ADDR_RATE_MODE_CONTROL
    && !wr_data_i[ACTIVE_BIT] && !transient_event_i && !tap_event_i
    |=> $stable(regs_reg[idx_of(ADDR_TRANSIENT_EVENT_SOURCE)])
    && $stable(regs_reg[idx_of(ADDR_TAP_EVENT_SOURCE)])
    && $stable(regs_reg[idx_of(ADDR_X_AXIS_OFFSET)])
    && ctrl1_now == ($past(ctrl1_now) & ~ACTIVE_MASK))
    else $error("standby entry changed a register");
  a_locked_offset: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    bank_write && active_now && ptr == ADDR_X_AXIS_OFFSET
    |=> $stable(regs_reg[idx_of(ADDR_X_AXIS_OFFSET)]))
    else $error("offset changed while active");
  a_ctrl2_keeps_rest: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    bank_write && active_now && ptr == ADDR_SLEEP_OVERSAMPLE_CONTROL
    |=> (ctrl2_now & ~SOFT_RESET_MASK)
      == ($past(ctrl2_now) & ~SOFT_RESET_MASK)
    && soft_reset_now == $past(wr_data_i[SOFT_RESET_BIT]))
    else $error("control bits other than reset changed while active");
  a_standby_write_lands: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    bank_write && !active_now && !source_reg(ptr)
    |=> regs_reg[idx_of($past(ptr))] == $past(wr_data_i))
    else $error("standby write was not stored");
  a_reset_bit_clears: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    soft_reset_now
    |=> !soft_reset_o && !active_mode_o
    && regs_reg[idx_of(ADDR_Z_AXIS_OFFSET)] == REG_RESET)
    else $error("soft reset left the bank set");
  a_mode_needs_write: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    !soft_reset_now && !(bank_write && ptr == ADDR_RATE_MODE_CONTROL)
    |=> $stable(active_mode_o))
    else $error("active mode changed without a control write");
  a_tap_clr_pulse: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    bank_write && ptr >= ADDR_TAP_THRESHOLD_X
    && ptr <= ADDR_TAP_THRESHOLD_Z
    |=> tap_debounce_clr_o && !transient_debounce_clr_o)
    else $error("tap debounce clear missing");
  a_count_clr_pulse: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    bank_write && ptr == ADDR_TRANSIENT_DEBOUNCE
    |=> transient_debounce_clr_o && !tap_debounce_clr_o)
    else $error("transient count write did not clear debounce");
  a_clr_needs_write: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    !bank_write |=> !transient_debounce_clr_o && !tap_debounce_clr_o)
    else $error("debounce clear without a write");
  // Events are sticky and beat a same-cycle activation clear
  a_transient_event_set: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    transient_event_i && !soft_reset_now
    |=> (regs_reg[idx_of(ADDR_TRANSIENT_EVENT_SOURCE)]
      & $past(transient_event_data_i)) == $past(transient_event_data_i))
    else $error("transient event bits were lost");
  a_tap_event_set: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    tap_event_i && !soft_reset_now
    |=> (regs_reg[idx_of(ADDR_TAP_EVENT_SOURCE)]
      & $past(tap_event_data_i)) == $past(tap_event_data_i))
    else $error("tap event bits were lost");
  a_trans_src_read_only: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    wr_strobe_i && ptr == ADDR_TRANSIENT_EVENT_SOURCE
    && !transient_event_i && !soft_reset_now
    |=> $stable(regs_reg[idx_of(ADDR_TRANSIENT_EVENT_SOURCE)]))
    else $error("transient source changed on write");
  a_outside_write_ignored: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    wr_strobe_i && !in_bank(ptr) && !soft_reset_now
    && !transient_event_i && !tap_event_i
    |=> $stable(reg_image_o))
    else $error("write outside the bank changed a register");
  a_outside_read_zero: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    rd_strobe_i && !in_bank(ptr)
    |=> rd_valid_o && rd_data_o == READ_OUTSIDE)
    else $error("read outside the bank was not zero");
  a_valid_one_cycle: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    !rd_strobe_i |=> !rd_valid_o && $stable(rd_data_o))
    else $error("read valid without a read strobe");
endmodule // aurb_upper_regs

// File: verification/aurb_host_model.sv
// Register-bus host model driving the upper register bank
`timescale 1ns/1ps
module aurb_host_model (
  input wire logic mclk_i,
  input wire logic [7:0] rd_data_i,
  input wire logic rd_valid_i,
  output logic stop_o,
  output logic addr_load_o,
  output logic [7:0] addr_o,
  output logic wr_strobe_o,
  output logic [7:0] wr_data_o,
  output logic rd_strobe_o
);
  // ==========================================================
  // Idle state
  initial begin
    stop_o = 1'b0;
    addr_load_o = 1'b0;
    wr_strobe_o = 1'b0;
    rd_strobe_o = 1'b0;
    addr_o = 8'h00;
    wr_data_o = 8'h00;
  end
  // ==========================================================
  // Bus cycles
  // Released data lines show the inverse of the last byte, so stale
  // values never look like a fresh request
  task automatic load(input logic [7:0] a);
    @(posedge mclk_i);
    #1;
    addr_load_o = 1'b1;
    addr_o = a;
    @(posedge mclk_i);
    #1;
    addr_load_o = 1'b0;
    addr_o = ~a;
  endtask
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    load(a);
    wr_strobe_o = 1'b1;
    wr_data_o = d;
    @(posedge mclk_i);
    #1;
    wr_strobe_o = 1'b0;
    wr_data_o = ~d;
  endtask
  // A missing valid turns the byte unknown, so the compare fails
  task automatic read(output logic [7:0] d);
    @(posedge mclk_i);
    #1;
    rd_strobe_o = 1'b1;
    @(posedge mclk_i);
    #1;
    rd_strobe_o = 1'b0;
    d = (rd_valid_i === 1'b1) ? rd_data_i : 8'hxx;
  endtask
  task automatic stop();
    @(posedge mclk_i);
    #1;
    stop_o = 1'b1;
    @(posedge mclk_i);
    #1;
    stop_o = 1'b0;
  endtask
endmodule // aurb_host_model

// File: verification/accel_upper_register_bank_tb_top.sv
// Self-checking testbench of the upper register bank
`timescale 1ns/1ps
module accel_upper_register_bank_tb_top;
  import aurb_pkg::*;
  logic mclk_i;
  logic rstn_i;
  logic stop, addr_load, wr_strobe, rd_strobe, rd_valid;
  logic tr_ev, tap_ev, active, soft_rst, tr_clr, tap_clr;
  logic [7:0] addr, wr_data, rd_data, tr_data, tap_data, a, d;
  logic [REG_COUNT*8-1:0] image;
  logic [7:0] e [REG_COUNT];
  int fails = 0;
  int n_compared = 0;
  // ==========================================================
  // Clock, instances, watchdog
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  aurb_host_model i_aurb_host_model (.mclk_i(mclk_i), .rd_data_i(rd_data),
    .rd_valid_i(rd_valid), .stop_o(stop), .addr_load_o(addr_load),
    .addr_o(addr), .wr_strobe_o(wr_strobe), .wr_data_o(wr_data),
    .rd_strobe_o(rd_strobe));
  aurb_upper_regs i_aurb_upper_regs (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .stop_i(stop), .addr_load_i(addr_load), .addr_i(addr),
    .wr_strobe_i(wr_strobe), .wr_data_i(wr_data), .rd_strobe_i(rd_strobe),
    .transient_event_i(tr_ev), .transient_event_data_i(tr_data),
    .tap_event_i(tap_ev), .tap_event_data_i(tap_data),
    .rd_data_o(rd_data), .rd_valid_o(rd_valid), .active_mode_o(active),
    .soft_reset_o(soft_rst), .transient_debounce_clr_o(tr_clr),
    .tap_debounce_clr_o(tap_clr), .reg_image_o(image));
  // Tests need under 2000 cycles
  initial begin
    #100000;
    fails++;
    final_report();
  end
  // ==========================================================
  // Helpers
  function automatic logic [7:0] val(input logic [7:0] x);
    // Keeps the active and soft reset bits clear while loading
    return (x & 8'h3e) | 8'h80;
  endfunction
  function automatic logic [7:0] exp_at(input logic [7:0] x);
    if (x >= ADDR_FIRST && x <= ADDR_LAST) return e[x - ADDR_FIRST];
    return READ_OUTSIDE;
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    n_compared++;
    if (seen !== want) begin
      fails++;
      $display("ERROR %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic chk_image();
    for (int i = 0; i < REG_COUNT; i++) begin
      check(image[i*8 +: 8], e[i]);
    end
  endtask
  task automatic final_report();
    if (fails == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ==========================================================
  // Tests
  initial begin
    rstn_i = 1'b0;
    tr_ev = 1'b0;
    tap_ev = 1'b0;
    tr_data = 8'h00;
    tap_data = 8'h00;
    foreach (e[i]) e[i] = REG_RESET;
    repeat (16) @(posedge mclk_i);
    #1;
    rstn_i = 1'b1;
    chk_image();
    for (a = ADDR_FIRST; a <= ADDR_LAST; a++) begin
      i_aurb_host_model.write(a, val(a));
      check({6'h00, tap_clr, tr_clr}, {6'h00, a >= 8'h23 && a <= 8'h25,
        a == 8'h1f || a == 8'h20});
      if (a != 8'h1e && a != 8'h22) e[a - ADDR_FIRST] = val(a);
    end
    chk_image();
    // Runs past the wrap all the way round to the first register
    i_aurb_host_model.load(ADDR_FIRST);
    a = ADDR_FIRST;
    repeat (38) begin
      i_aurb_host_model.read(d);
      check(d, exp_at(a));
      a = (a == ADDR_LAST) ? ADDR_WRAP : a + ADDR_STEP;
    end
    i_aurb_host_model.write(ADDR_TRANSIENT_THRESHOLD, 8'h77);
    e[2] = 8'h77;
    i_aurb_host_model.read(d);
    check(d, 8'h77);
    i_aurb_host_model.load(ADDR_FIRST);
    i_aurb_host_model.stop();
    i_aurb_host_model.read(d);
    check(d, READ_OUTSIDE);
    @(posedge mclk_i);
    #1;
    tr_ev = 1'b1;
    tap_ev = 1'b1;
    tr_data = 8'h33;
    tap_data = 8'h44;
    @(posedge mclk_i);
    #1;
    tr_ev = 1'b0;
    tap_ev = 1'b0;
    tr_data = 8'hcc;
    tap_data = 8'hbb;
    e[1] = 8'h33;
    e[5] = 8'h44;
    chk_image();
    // Host configures in standby, then activates
    i_aurb_host_model.write(ADDR_RATE_MODE_CONTROL, val(8'h2a) | ACTIVE_MASK);
    e[13] = val(8'h2a) | ACTIVE_MASK;
    e[1] = 8'h00;
    e[5] = 8'h00;
    check({7'h00, active}, 8'h01);
    chk_image();
    i_aurb_host_model.write(ADDR_TRANSIENT_CONFIG, 8'hff);
    i_aurb_host_model.write(ADDR_X_AXIS_OFFSET, 8'hff);
    chk_image();
    i_aurb_host_model.write(ADDR_TAP_THRESHOLD_Z, 8'h55);
    e[8] = 8'h55;
    check({7'h00, tap_clr}, 8'h01);
    i_aurb_host_model.write(ADDR_RATE_MODE_CONTROL, 8'h00);
    e[13] = val(8'h2a);
    check({7'h00, active}, 8'h00);
    chk_image();
    i_aurb_host_model.write(ADDR_RATE_MODE_CONTROL, val(8'h2a) | ACTIVE_MASK);
    i_aurb_host_model.write(ADDR_SLEEP_OVERSAMPLE_CONTROL, SOFT_RESET_MASK);
    check({7'h00, soft_rst}, 8'h01);
    @(posedge mclk_i);
    #1;
    foreach (e[i]) e[i] = REG_RESET;
    chk_image();
    // Out-of-bank write is dropped; an event beats a same-cycle activation
    i_aurb_host_model.write(ADDR_WRAP, 8'hff);
    chk_image();
    fork
      i_aurb_host_model.write(ADDR_RATE_MODE_CONTROL, ACTIVE_MASK);
      begin
        repeat (2) @(posedge mclk_i);
        #1;
        tr_ev = 1'b1;
        tr_data = 8'h5a;
        @(posedge mclk_i);
        #1;
        tr_ev = 1'b0;
        tr_data = 8'ha5;
      end
    join
    e[1] = 8'h5a;
    e[13] = ACTIVE_MASK;
    chk_image();
    final_report();
  end
endmodule // accel_upper_register_bank_tb_top
